// ### rtl/tfi_pkg.sv
// Package: register map, field layout, codeword geometry for the TX FEC inject block
`default_nettype none
package tfi_pkg;
  // ********************************
  // Codeword geometry
  // ********************************
  localparam int SYM_BITS        = 10;
  localparam int SYMS_PER_CW     = 528;
  localparam int SYMS_PER_GROUP  = 8;
  localparam int GROUP_BITS      = SYM_BITS * SYMS_PER_GROUP;
  localparam int GROUPS_PER_CW   = SYMS_PER_CW / SYMS_PER_GROUP;
  localparam logic [6:0] LAST_GROUP = 7'(GROUPS_PER_CW - 1);
  localparam int FIFO_DEPTH      = 4;

  // ********************************
  // Register indices (byte address is four times the index)
  // ********************************
  localparam logic [11:0] IDX_REVISION = 12'hC00;
  localparam logic [11:0] IDX_NAME0    = 12'hC01;
  localparam logic [11:0] IDX_NAME1    = 12'hC02;
  localparam logic [11:0] IDX_NAME2    = 12'hC03;
  localparam logic [11:0] IDX_CONTROL  = 12'hC04;
  localparam logic [11:0] IDX_PATTERN  = 12'hC05;
  localparam logic [11:0] IDX_BYPASS   = 12'hC06;
  localparam int          ADDR_BITS    = 14;

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int CTRL_CONT_POS   = 0;
  localparam int CTRL_SINGLE_POS = 4;
  localparam int PAT_BITS_LSB    = 16;
  localparam int PAT_SYMS_LSB    = 8;
  localparam int PAT_GROUP_LSB   = 0;
  localparam int BYPASS_POS      = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
  localparam logic [31:0] BYPASS_RESET  = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
endpackage
`default_nettype wire

// ### rtl/tfi_fifo.sv
// Small valid/ready FIFO with parameterised width and depth
`default_nettype none
module tfi_fifo #(
  parameter int WIDTH = 81,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
  } tfi_fifo_state_type;

  tfi_fifo_state_type state;
  tfi_fifo_state_type next_state;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready  = (state.count != (PW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = mem[state.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr_ptr = (state.wr_ptr == PW'(DEPTH-1)) ? '0 : state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = (state.rd_ptr == PW'(DEPTH-1)) ? '0 : state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  // Storage has no reset; only the pointers and the count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[state.wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule // tfi_fifo
`default_nettype wire

// ### rtl/tfi_corrupt.sv
// Per-symbol XOR corrupter for one 80-bit group
`default_nettype none
module tfi_corrupt (
  input  wire logic [tfi_pkg::GROUP_BITS-1:0]     group_in,
  input  wire logic                               enable,
  input  wire logic [tfi_pkg::SYMS_PER_GROUP-1:0] sym_mask,
  input  wire logic [tfi_pkg::SYM_BITS-1:0]       bit_mask,
  output logic      [tfi_pkg::GROUP_BITS-1:0]     group_out
);
  // Symbol k of the group sits in bits [10k+9:10k]
  for (genvar k = 0; k < tfi_pkg::SYMS_PER_GROUP; k++) begin : g_sym
    assign group_out[k*tfi_pkg::SYM_BITS +: tfi_pkg::SYM_BITS] =
      group_in[k*tfi_pkg::SYM_BITS +: tfi_pkg::SYM_BITS] ^
      ((enable && sym_mask[k]) ? bit_mask : '0);
  end
endmodule // tfi_corrupt
`default_nettype wire

// ### rtl/tfi_top.sv
// TX FEC error injection stage with APB register slave
//
// Design decision made here: the APB register port.
`default_nettype none
// Functional notes
// - Single inject corrupts one codeword, self-clears
// - Continuous inject corrupts every codeword
// - Codeword is 528 ten-bit symbols
// - Eight-symbol groups, 66 per codeword
// - Pattern holds bit mask, symbol mask, group number
// - One bypass bit drives TX and RX
// - Read-only revision word at base
// - Three read-only name words, four chars
// - Control registers reset zero, reserved read zero
module tfi_top #(
  parameter logic [31:0] REVISION_ID = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] NAME_WORD0  = 32'h6665_6331, // Arbitrary value
  parameter logic [31:0] NAME_WORD1  = 32'h696E_6A74, // Arbitrary value
  parameter logic [31:0] NAME_WORD2  = 32'h7874_7831  // Arbitrary value
) (
  input  wire logic                              CORE_CLK,
  input  wire logic                              RST_N,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [tfi_pkg::ADDR_BITS-1:0]     PADDR,
  input  wire logic [31:0]                       PWDATA,
  output logic      [31:0]                       PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  input  wire logic [tfi_pkg::GROUP_BITS-1:0]    TX_IN_DATA,
  input  wire logic                              TX_IN_SOC,
  input  wire logic                              TX_IN_VALID,
  output logic                                   TX_IN_READY,
  output logic      [tfi_pkg::GROUP_BITS-1:0]    TX_OUT_DATA,
  output logic                                   TX_OUT_SOC,
  output logic                                   TX_OUT_VALID,
  input  wire logic                              TX_OUT_READY,
  output logic                                   TX_FEC_BYPASS,
  output logic                                   RX_FEC_BYPASS
);
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic                                   ctrl_cont;
    logic                                   ctrl_single;
    logic [tfi_pkg::SYM_BITS-1:0]           pat_bits;
    logic [tfi_pkg::SYMS_PER_GROUP-1:0]     pat_syms;
    logic [6:0]                             pat_group;
    logic                                   bypass;
    logic                                   apb_ack;
    logic                                   apb_err;
    logic [31:0]                            rdata;
    logic [6:0]                             group_cnt;
    logic [tfi_pkg::GROUP_BITS-1:0]         out_data;
    logic                                   out_soc;
    logic                                   out_valid;
  } tfi_state_type;

  tfi_state_type state;
  tfi_state_type next_state;

  // ********************************
  // Input FIFO
  // ********************************
  logic [tfi_pkg::GROUP_BITS:0]   fifo_out;
  logic                           fifo_valid;
  logic                           fifo_ready;
  logic                           consume;
  logic [6:0]                     cur_group;
  logic                           hit_group;
  logic                           do_inject;
  logic [tfi_pkg::GROUP_BITS-1:0] corrupted;

  tfi_fifo #(
    .WIDTH (tfi_pkg::GROUP_BITS + 1),
    .DEPTH (tfi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .in_data   ({TX_IN_SOC, TX_IN_DATA}),
    .in_valid  (TX_IN_VALID),
    .in_ready  (TX_IN_READY),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // Output stage stalls the FIFO, so PMA back-pressure reaches the PCS
  assign fifo_ready = !state.out_valid || TX_OUT_READY;
  assign consume    = fifo_valid && fifo_ready;

  // ********************************
  // Codeword tracking and injection
  // ********************************
  // A start-of-codeword flag resynchronises the group count
  assign cur_group = fifo_out[tfi_pkg::GROUP_BITS] ? 7'h00 : state.group_cnt;
  assign hit_group = (cur_group == state.pat_group);
  // Bypass passes traffic untouched, so no injection either
  assign do_inject = consume && hit_group && !state.bypass &&
                     (state.ctrl_cont || state.ctrl_single);

  tfi_corrupt u_corrupt (
    .group_in  (fifo_out[tfi_pkg::GROUP_BITS-1:0]),
    .enable    (do_inject),
    .sym_mask  (state.pat_syms),
    .bit_mask  (state.pat_bits),
    .group_out (corrupted)
  );

  // ********************************
  // APB read mux
  // ********************************
  logic [11:0] reg_idx;
  logic        addr_hit;
  logic [31:0] read_word;

  assign reg_idx = PADDR[tfi_pkg::ADDR_BITS-1:2];

  always_comb begin
    addr_hit  = 1'b1;
    read_word = tfi_pkg::READ_ZERO;
    case (reg_idx)
      tfi_pkg::IDX_REVISION: begin
        read_word = REVISION_ID;
      end
      tfi_pkg::IDX_NAME0: begin
        read_word = NAME_WORD0;
      end
      tfi_pkg::IDX_NAME1: begin
        read_word = NAME_WORD1;
      end
      tfi_pkg::IDX_NAME2: begin
        read_word = NAME_WORD2;
      end
      tfi_pkg::IDX_CONTROL: begin
        read_word[tfi_pkg::CTRL_CONT_POS]   = state.ctrl_cont;
        read_word[tfi_pkg::CTRL_SINGLE_POS] = state.ctrl_single;
      end
      tfi_pkg::IDX_PATTERN: begin
        read_word[tfi_pkg::PAT_BITS_LSB +: tfi_pkg::SYM_BITS]       = state.pat_bits;
        read_word[tfi_pkg::PAT_SYMS_LSB +: tfi_pkg::SYMS_PER_GROUP] = state.pat_syms;
        read_word[tfi_pkg::PAT_GROUP_LSB +: 7]                      = state.pat_group;
      end
      tfi_pkg::IDX_BYPASS: begin
        read_word[tfi_pkg::BYPASS_POS] = state.bypass;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ********************************
  // Next state
  // ********************************
  logic apb_access;
  logic apb_commit;

  // One wait state: answer in the cycle after the access phase opens
  assign apb_access = PSEL && PENABLE;
  assign apb_commit = apb_access && state.apb_ack;

  always_comb begin
    next_state = state;

    // Stream path
    if (consume) begin
      next_state.out_data  = corrupted;
      next_state.out_soc   = fifo_out[tfi_pkg::GROUP_BITS];
      next_state.out_valid = 1'b1;
      next_state.group_cnt = (cur_group == tfi_pkg::LAST_GROUP) ?
                             7'h00 : cur_group + 7'h01;
    end else if (TX_OUT_READY) begin
      next_state.out_valid = 1'b0;
    end

    // Single shot ends after its one codeword has been hit
    if (do_inject && state.ctrl_single) begin
      next_state.ctrl_single = 1'b0;
    end

    // APB slave
    if (apb_access && !state.apb_ack) begin
      next_state.apb_ack = 1'b1;
      next_state.apb_err = !addr_hit;
      next_state.rdata   = PWRITE ? tfi_pkg::READ_ZERO : read_word;
    end
    if (apb_commit) begin
      next_state.apb_ack = 1'b0;
      next_state.apb_err = 1'b0;
      // A write lands after the hardware clear, so software re-arming wins
      if (PWRITE) begin
        case (reg_idx)
          tfi_pkg::IDX_CONTROL: begin
            next_state.ctrl_cont   = PWDATA[tfi_pkg::CTRL_CONT_POS];
            next_state.ctrl_single = PWDATA[tfi_pkg::CTRL_SINGLE_POS];
          end
          tfi_pkg::IDX_PATTERN: begin
            next_state.pat_bits  = PWDATA[tfi_pkg::PAT_BITS_LSB +: tfi_pkg::SYM_BITS];
            next_state.pat_syms  = PWDATA[tfi_pkg::PAT_SYMS_LSB +: tfi_pkg::SYMS_PER_GROUP];
            next_state.pat_group = PWDATA[tfi_pkg::PAT_GROUP_LSB +: 7];
          end
          tfi_pkg::IDX_BYPASS: begin
            next_state.bypass = PWDATA[tfi_pkg::BYPASS_POS];
          end
          default: begin
            // Read-only and unmapped words ignore writes
            next_state.bypass = state.bypass;
          end
        endcase
      end
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state             <= '0;
      state.ctrl_cont   <= tfi_pkg::CTRL_RESET[tfi_pkg::CTRL_CONT_POS];
      state.ctrl_single <= tfi_pkg::CTRL_RESET[tfi_pkg::CTRL_SINGLE_POS];
      state.pat_bits    <= tfi_pkg::PATTERN_RESET[tfi_pkg::PAT_BITS_LSB +: tfi_pkg::SYM_BITS];
      state.pat_syms    <= tfi_pkg::PATTERN_RESET[tfi_pkg::PAT_SYMS_LSB +: 8];
      state.pat_group   <= tfi_pkg::PATTERN_RESET[tfi_pkg::PAT_GROUP_LSB +: 7];
      state.bypass      <= tfi_pkg::BYPASS_RESET[tfi_pkg::BYPASS_POS];
    end else begin
      state <= next_state;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign PRDATA        = state.rdata;
  assign PREADY        = state.apb_ack;
  assign PSLVERR       = state.apb_ack && state.apb_err;
  assign TX_OUT_DATA   = state.out_data;
  assign TX_OUT_SOC    = state.out_soc;
  assign TX_OUT_VALID  = state.out_valid;
  assign TX_FEC_BYPASS = state.bypass;
  assign RX_FEC_BYPASS = state.bypass;
endmodule // tfi_top
`default_nettype wire

// ### bench/tfi_sva.sv
// Port-level assertions for the TX FEC inject block
`default_nettype none
module tfi_sva #(
  parameter logic [31:0] REVISION_ID = 32'h0000_0001
) (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [79:0] TX_OUT_DATA,
  input wire logic        TX_OUT_SOC,
  input wire logic        TX_OUT_VALID,
  input wire logic        TX_OUT_READY,
  input wire logic        TX_FEC_BYPASS,
  input wire logic        RX_FEC_BYPASS
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic        rd_ok;
  logic [11:0] idx;
  assign rd_ok = PREADY && !PWRITE && !PSLVERR;
  assign idx   = PADDR[13:2];
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  a_bypass_pair: assert property (TX_FEC_BYPASS == RX_FEC_BYPASS)
    else $error("bypass outputs differ");
  a_bypass_read: assert property (
    rd_ok && idx == tfi_pkg::IDX_BYPASS |-> PRDATA == {31'h0000_0000, TX_FEC_BYPASS})
    else $error("bypass read differs from output");
  a_rev_fixed: assert property (
    rd_ok && idx == tfi_pkg::IDX_REVISION |-> PRDATA == REVISION_ID)
    else $error("revision word wrong");
  a_ctrl_resvd: assert property (
    rd_ok && idx == tfi_pkg::IDX_CONTROL |-> (PRDATA & 32'hFFFF_FFEE) == 32'h0000_0000)
    else $error("control reserved bits set");
  a_err_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0000_0000)
    else $error("refused read returns data");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_wait: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
    else $error("access phase not two cycles");
  a_out_hold: assert property ( // Output stands until taken
    TX_OUT_VALID && !TX_OUT_READY |=> TX_OUT_VALID && $stable({TX_OUT_SOC, TX_OUT_DATA}))
    else $error("output group changed while stalled");
endmodule // tfi_sva
bind tfi_top tfi_sva #(.REVISION_ID(REVISION_ID)) u_sva (.CORE_CLK, .RST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .TX_OUT_DATA, .TX_OUT_SOC, .TX_OUT_VALID,
  .TX_OUT_READY, .TX_FEC_BYPASS, .RX_FEC_BYPASS);
`default_nettype wire

// ### bench/tfi_sink.sv
// Downstream transceiver-side sink model that records groups
`default_nettype none
module tfi_sink (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        valid,
  input  wire logic [80:0] data,
  output logic             ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [80:0] got[$];
  logic [1:0]  cnt;
  // ********************************
  // Stalls three cycles in four so the FIFO fills and refuses
  // ********************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      ready <= 1'b0;
    end else begin
      if (valid && ready) got.push_back(data);
      cnt <= cnt + 2'h1;
      ready <= !stall || (cnt == 2'h3);
    end
  end
endmodule // tfi_sink
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench: register access and codeword error injection
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] REV = 32'h0000_00A1; // Arbitrary value
  localparam logic [31:0] NM0 = 32'h0000_00B0; // Arbitrary value
  localparam logic [31:0] NM1 = 32'h0000_00B1; // Arbitrary value
  localparam logic [31:0] NM2 = 32'h0000_00B2; // Arbitrary value
  localparam logic [31:0] EXP0 [7] = '{REV, NM0, NM1, NM2, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] EXP1 [7] = '{REV, NM0, NM1, NM2, 32'h0, 32'h03FF_FF40, 32'h0};
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [79:0] in_data;
  logic        in_soc;
  logic        in_valid;
  logic        in_ready;
  logic [79:0] out_data;
  logic        out_soc;
  logic        out_valid;
  logic        out_ready;
  logic        tx_byp;
  logic        rx_byp;
  logic        stall;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          compares;
  int          cycles;
  tfi_top #(.REVISION_ID(REV), .NAME_WORD0(NM0), .NAME_WORD1(NM1), .NAME_WORD2(NM2)) u_dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_IN_DATA(in_data), .TX_IN_SOC(in_soc), .TX_IN_VALID(in_valid), .TX_IN_READY(in_ready),
    .TX_OUT_DATA(out_data), .TX_OUT_SOC(out_soc), .TX_OUT_VALID(out_valid),
    .TX_OUT_READY(out_ready), .TX_FEC_BYPASS(tx_byp), .RX_FEC_BYPASS(rx_byp));
  tfi_sink u_sink (.clk(core_clk), .rst_n(rst_n), .stall(stall), .valid(out_valid),
    .data({out_soc, out_data}), .ready(out_ready));
  // ********************************
  // Tasks
  // ********************************
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [80:0] seen, input logic [80:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One idle edge after release keeps back-to-back calls from double-driving
  task automatic apb(input logic w, input logic [11:0] ix, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [79:0] gd(input int i);
    return {16'(i), 64'hC3A5_96F0_0FF0_5A3C};
  endfunction
  task automatic run(input int n, input logic [9:0] bm, input logic [7:0] sm, input int g,
                     input logic [1:0] hit);
    logic [80:0] e;
    int i;
    u_sink.got.delete();
    for (i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_soc <= (i % 66 == 0);
      in_data <= gd(i);
      do @(posedge core_clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    while (u_sink.got.size() < n) @(posedge core_clk);
    for (i = 0; i < n; i++) begin
      e = {i % 66 == 0, gd(i)};
      for (int k = 0; k < 8; k++)
        if (hit[i / 66] && i % 66 == g && sm[k]) e[10*k +: 10] ^= bm;
      chk("group", u_sink.got[i], e);
    end
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    in_data = 80'h0;
    in_soc = 1'b0;
    in_valid = 1'b0;
    stall = 1'b1;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int j = 0; j < 7; j++) begin
      apb(1'b0, 12'hC00 + 12'(j), 32'h0000_0000);
      chk("reset read", {err, rd}, {1'b0, EXP0[j]});
      apb(1'b1, 12'hC00 + 12'(j), 32'hFFFF_FFC0);
      apb(1'b0, 12'hC00 + 12'(j), 32'h0000_0000);
      chk("write read", {err, rd}, {1'b0, EXP1[j]});
    end
    apb(1'b1, 12'hC07, 32'hFFFF_FFFF);
    chk("unmapped write", err, 1'b1);
    apb(1'b0, 12'hC07, 32'h0000_0000);
    chk("unmapped read", {err, rd}, {1'b1, 32'h0});
    chk("bypass off", {tx_byp, rx_byp}, 2'h0);
    apb(1'b1, 12'hC05, 32'h0155_8141);
    apb(1'b1, 12'hC04, 32'h0000_0001);
    run(132, 10'h155, 8'h81, 65, 2'h3);
    apb(1'b1, 12'hC05, 32'h0155_8100);
    apb(1'b1, 12'hC04, 32'h0000_0010);
    run(132, 10'h155, 8'h81, 0, 2'h1);
    apb(1'b0, 12'hC04, 32'h0000_0000);
    chk("single cleared", rd, 32'h0);
    apb(1'b1, 12'hC04, 32'h0000_0001);
    apb(1'b1, 12'hC06, 32'hFFFF_FFFF);
    apb(1'b0, 12'hC04, 32'h0000_0000);
    chk("cont read", rd, 32'h1);
    apb(1'b0, 12'hC06, 32'h0000_0000);
    chk("bypass read", rd, 32'h1);
    chk("bypass on", {tx_byp, rx_byp}, 2'h3);
    run(66, 10'h155, 8'h81, 0, 2'h0);
    apb(1'b1, 12'hC06, 32'h0000_0000);
    apb(1'b1, 12'hC04, 32'h0000_0000);
    stall <= 1'b0;
    run(66, 10'h155, 8'h81, 0, 2'h0);
    // Second reset after the last run: the pattern must drop back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 12'hC05, 32'h0000_0000);
    chk("pattern after reset", rd, 32'h0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
